// [rtl/spi_port_pkg.sv]
`default_nettype none
package spi_port_pkg;

	// command word taken from one frame
	typedef struct packed {
		logic       write; // 1 = write, 0 = read
		logic [6:0] addr;  // register address
		logic [7:0] data;  // write data
	} cmd_t;

	// register addresses handled inside the port
	localparam logic [6:0] ADDR_INPUT     = 7'h02;
	localparam logic [6:0] ADDR_MAIN_FAULT_STATUS_REGISTER    = 7'h04;
	localparam logic [6:0] ADDR_SECONDARY_FAULT_STATUS    = 7'h1c;
	localparam logic [6:0] ADDR_SECONDARY_FAULT_STATUS_EN = 7'h1e;
	localparam logic [6:0] ADDR_GPO       = 7'h22;
	localparam logic [6:0] ADDR_MAIN_FAULT_STATUS_REGISTER_EN = 7'h24;

	// values after reset
	localparam logic [7:0] MAIN_FAULT_STATUS_REGISTER_EN_RESET = 8'hc0;
	localparam logic [7:0] SECONDARY_FAULT_STATUS_EN_RESET = 8'h00;
	localparam logic [7:0] GPO_RESET       = 8'h00;

	// field positions
	localparam int F1_CRC     = 7;
	localparam int F1_POR     = 6;
	localparam int F1_SECONDARY_FAULT_STATUS  = 5;
	localparam int F1_SLOW    = 2;
	localparam int F1_SMISS   = 1;
	localparam int F2_CLK8    = 4;
	localparam int F2_OTEMP   = 3;
	localparam int GPO_STICKY = 7;

	// frame layout
	localparam logic [7:0] LEN_CRC   = 8'h18;
	localparam logic [7:0] LEN_PLAIN = 8'h10;
	localparam logic [7:0] LEN_BYTE  = 8'h08;
	localparam int CRC_DATA_BITS     = 19;
	localparam logic [4:0] CRC_INIT  = 5'h07;
	localparam logic [5:0] CRC_POLY  = 6'h35;

	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int POWERUP_NS     = 1000;
	localparam int POWERUP_CYCLES =
		(POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// remainder of {19 data bits, init word} over the 5-bit polynomial
	function automatic logic [4:0] crc5(input logic [18:0] bits);
		logic [23:0] word;
		logic [5:0]  rem;
		word = {bits, CRC_INIT};
		rem  = 6'h00;
		for (int i = 23; i >= 0; i--) begin
			rem = {rem[4:0], word[i]};
			if (rem[5]) begin
				rem = rem ^ CRC_POLY;
			end
		end
		return rem[4:0];
	endfunction

endpackage
`default_nettype wire

// [rtl/two_entry_buffer.sv]
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             clock,     // system clock
	input  wire logic             rst,       // async reset, high
	input  wire logic             in_valid,  // word offered
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // offered word
	output logic                  out_valid, // head word present
	input  wire logic             out_ready, // drain takes head
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || WIDTH < 1) begin : g_chk
			$error("two_entry_buffer needs DEPTH >= 2, WIDTH >= 1");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic [CW-1:0]    land;
	logic             push;
	logic             pop;

	// head sits at entry 0, so the outputs come straight from flops
	assign out_valid  = vld[0];
	assign out_data   = mem[0];
	assign in_ready   = (count != CW'(DEPTH));
	assign push       = in_valid & in_ready;
	assign pop        = vld[0] & out_ready;
	assign land       = pop ? count - CW'(1) : count;
	assign next_count = count + CW'(push) - CW'(pop);

	// occupancy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// each entry either takes the new word or moves toward the head
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					mem[i] <= '0;
					vld[i] <= 1'b0;
				end else begin
					vld[i] <= (next_count > CW'(i));
					if (push && land == CW'(i)) begin
						mem[i] <= in_data;
					end else if (pop) begin
						mem[i] <= (i < DEPTH - 1) ? mem[(i + 1) % DEPTH]
							: mem[i];
					end
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// [rtl/octal_input_spi_frame_port.sv]
// How it works
// [R1] host waits for ready_n low; frames before then are not taken
// [R2] power-on flag starts at 1, alarm asserted; host write of 0 clears it
// [R3] defaults: only crc error and power-on flags enabled onto alarm
// [R4] faults drive an open-drain, active-low alarm pin
// [R5] sticky or following alarm selectable; fault enables held here
// [R6] host reads main fault status, then secondary when summary bit set
// [R7] reading a fault register clears it; persisting condition sets again
// [R8] crc direct frame: rw, 7-bit address, data, 3 fill, 5-bit crc
// [R9] crc frames return inputs, data or zeros, supply flags, 0, crc
// [R10] plain direct frame 16 bits; read data returned in same frame
// [R11] crc chain frames return data only after a preceding read
// [R12] plain chain frames return data only after a preceding read
// [R13] host makes crc and write data for every frame it sends
// [R14] a no-op is a write, so the next chain frame returns zeros
// [R15] channel states frozen when chip select or freeze input falls
// [R16] supply flags frozen by chip select only, not by freeze input
// [R17] read returns addressed register; supply flags mirror main status
// [R18] plain modes: eight-clock frame gives inputs, command ignored
// [R19] crc: polynomial x5+x4+x2+1 over 19 bits, init word 00111
// [R20] input sampled on rising sclk, output changed on falling sclk
// [R21] clock count not multiple of 8 discards frame, sets error flag
// [R22] failed crc ignores command, sets flag until a good frame
// [R23] fill bits are ignored except inside the crc
`default_nettype none
module octal_input_spi_frame_port #(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                clock,          // 100 MHz clock
	input  wire logic                rst,            // async reset, high
	input  wire logic                sclk,           // serial clock pin
	input  wire logic                cs_n,           // chip select pin
	input  wire logic                sdi,            // serial data in
	output logic                     sdo,            // serial data out
	output logic                     sdo_oe,         // sdo driven
	input  wire logic                sample_freeze_n,// input freeze pin
	input  wire logic                crc_select_pin, // 1 = no crc
	input  wire logic                chain_select_pin,// 1 = daisy chain
	input  wire logic [7:0]          channel_in,     // field input states
	input  wire logic                supply_low_in,  // supply low level
	input  wire logic                supply_miss_in, // supply missing
	input  wire logic                overtemp_in,    // overtemperature
	output logic                     ready_n,        // low = powered up
	output logic                     alarm_n_out,    // alarm level, 0
	output logic                     alarm_n_oe,     // alarm pulled low
	output logic                     wr_valid,       // write to outside
	output spi_port_pkg::cmd_t       wr_cmd,         // outside write
	input  wire logic                wr_ready,       // outside takes it
	output logic [6:0]               rd_addr,        // outside read addr
	input  wire logic [7:0]          rd_data         // outside read data
);
	localparam int PW = $clog2(spi_port_pkg::POWERUP_CYCLES + 1);
	localparam int SW = 17;

	generate
		if (BUF_DEPTH < 2) begin : g_chk
			$error("octal_input_spi_frame_port needs BUF_DEPTH >= 2");
		end
	endgenerate

	// two-flop synchronisers for every pin input
	logic [SW-1:0] sy1;
	logic [SW-1:0] sy2;
	wire  [SW-1:0] pins = {sclk, cs_n, sdi, sample_freeze_n,
		crc_select_pin, chain_select_pin, supply_low_in,
		supply_miss_in, overtemp_in, channel_in};

	genvar g;
	generate
		for (g = 0; g < SW; g++) begin : g_sync
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sy1[g] <= 1'b0;
					sy2[g] <= 1'b0;
				end else begin
					sy1[g] <= pins[g];
					sy2[g] <= sy1[g];
				end
			end
		end
	endgenerate

	wire       sclk_s  = sy2[16];
	wire       cs_n_s  = sy2[15];
	wire       sdi_s   = sy2[14];
	wire       frz_n_s = sy2[13];
	wire       nocrc_s = sy2[12];
	wire       chain_s = sy2[11];
	wire       slow_s  = sy2[10];
	wire       smiss_s = sy2[9];
	wire       otemp_s = sy2[8];
	wire [7:0] chan_s  = sy2[7:0];
	logic sclk_d;
	logic cs_n_d;
	logic [PW-1:0] pu_cnt;
	logic in_frame;
	logic mode_crc;
	logic mode_chain;
	logic [7:0] bit_cnt;
	logic [23:0] in_shift;
	logic [23:0] out_word;
	logic [5:0] out_idx;
	logic [7:0] hold;
	logic load_pending;
	logic prev_read;
	logic crc_err;
	logic por;
	logic slow;
	logic smiss;
	logic clk8;
	logic otemp;
	logic [7:0] f1_en;
	logic [7:0] f2_en;
	logic [7:0] gpo;
	logic alarm_latched;
	logic exec_valid;
	spi_port_pkg::cmd_t exec_cmd;
	logic buf_ready;

	// edges seen on the synchronised pins
	wire sclk_rise = in_frame & sclk_s & ~sclk_d; // [R20]
	wire sclk_fall = in_frame & ~sclk_s & sclk_d; // [R20]
	wire cs_fall   = ~cs_n_s & cs_n_d & ~ready_n & ~exec_valid; // [R1]
	wire cs_rise   = in_frame & cs_n_s;

	// status register images
	wire f2_sum = (clk8 & f2_en[spi_port_pkg::F2_CLK8])
		| (otemp & f2_en[spi_port_pkg::F2_OTEMP]);
	wire [7:0] main_fault_status_register = {crc_err, por, f2_sum, 2'b00, slow, smiss, 1'b0};
	wire [7:0] secondary_fault_status = {3'b000, clk8, otemp, 3'b000};

	// read data mux: port-held registers, else the outside register file
	wire [7:0] read_value =
		(rd_addr == spi_port_pkg::ADDR_MAIN_FAULT_STATUS_REGISTER)    ? main_fault_status_register : // [R17]
		(rd_addr == spi_port_pkg::ADDR_SECONDARY_FAULT_STATUS)    ? secondary_fault_status :
		(rd_addr == spi_port_pkg::ADDR_MAIN_FAULT_STATUS_REGISTER_EN) ? f1_en  :
		(rd_addr == spi_port_pkg::ADDR_SECONDARY_FAULT_STATUS_EN) ? f2_en  :
		(rd_addr == spi_port_pkg::ADDR_GPO)       ? gpo    :
		(rd_addr == spi_port_pkg::ADDR_INPUT)     ? hold   : rd_data;

	// command decode at frame end; fill bits only enter the crc check
	wire [7:0] frame_len = mode_crc ? spi_port_pkg::LEN_CRC
		: spi_port_pkg::LEN_PLAIN;
	wire cmd_write = mode_crc ? in_shift[23] : in_shift[15]; // [R8] [R10]
	wire [6:0] cmd_addr = mode_crc ? in_shift[22:16] : in_shift[14:8];
	wire [7:0] cmd_data = mode_crc ? in_shift[15:8] : in_shift[7:0]; // [R23]
	wire crc_ok = spi_port_pkg::crc5(in_shift[23:5]) == in_shift[4:0];

	// frame verdicts at chip select release
	wire bad_count = cs_rise & (bit_cnt[2:0] != 3'h0); // [R21]
	wire short_rd  = cs_rise & ~bad_count & ~mode_crc
		& (bit_cnt == spi_port_pkg::LEN_BYTE); // [R18]
	wire too_short = cs_rise & ~bad_count & ~short_rd
		& (bit_cnt < frame_len);
	wire crc_bad   = cs_rise & ~bad_count & ~short_rd & mode_crc
		& (too_short | ~crc_ok); // [R22]
	wire valid     = cs_rise & ~bad_count & ~short_rd & ~too_short
		& (~mode_crc | crc_ok); // [R19] [R22]
	wire rd_f1  = valid & ~cmd_write
		& (cmd_addr == spi_port_pkg::ADDR_MAIN_FAULT_STATUS_REGISTER); // [R6]
	wire rd_f2  = valid & ~cmd_write
		& (cmd_addr == spi_port_pkg::ADDR_SECONDARY_FAULT_STATUS);
	wire wr_any = valid & cmd_write;
	wire wr_f1  = wr_any & (cmd_addr == spi_port_pkg::ADDR_MAIN_FAULT_STATUS_REGISTER);
	wire wr_f1e = wr_any & (cmd_addr == spi_port_pkg::ADDR_MAIN_FAULT_STATUS_REGISTER_EN);
	wire wr_f2e = wr_any & (cmd_addr == spi_port_pkg::ADDR_SECONDARY_FAULT_STATUS_EN);
	wire wr_gpo = wr_any & (cmd_addr == spi_port_pkg::ADDR_GPO);
	wire wr_ext = wr_any & ~wr_f1 & ~wr_f1e & ~wr_f2e & ~wr_gpo
		& (cmd_addr != spi_port_pkg::ADDR_SECONDARY_FAULT_STATUS)
		& (cmd_addr != spi_port_pkg::ADDR_INPUT);

	// outgoing bit: own word, own crc in crc modes, then pass-through in chain mode
	wire [5:0] next_idx = (out_idx == 6'h3f) ? out_idx : out_idx + 6'h01;
	wire [23:0] out_full = {out_word[23:5],
		mode_crc ? spi_port_pkg::crc5(out_word[23:5]) : 5'h00}; // [R9]
	wire past_own = {2'b00, next_idx} >= frame_len;
	wire [4:0] pick = 5'(5'd23 - next_idx[4:0]);
	wire [4:0] plain_pick = 5'(5'd15 - next_idx[4:0]);
	wire next_bit = past_own ? (mode_chain & in_shift[frame_len[4:0] - 5'h01])
		: mode_crc ? out_full[pick] : out_full[5'h08 + plain_pick];
	wire [7:0] chain_byte = (chain_s & prev_read) ? read_value : 8'h00;

	// power-up delay; no frame is taken while ready_n is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pu_cnt  <= '0;
			ready_n <= 1'b1;
		end else if (pu_cnt != PW'(spi_port_pkg::POWERUP_CYCLES)) begin
			pu_cnt <= pu_cnt + PW'(1);
		end else begin
			ready_n <= 1'b0; // [R1]
		end
	end

	// edge history of the synchronised pins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	// channel holding stage, open only while both freezes are high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold <= 8'h00;
		end else if (cs_n_s & frz_n_s) begin
			hold <= chan_s; // [R15]
		end
	end

	// frame framing and input shifting
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_frame   <= 1'b0;
			mode_crc   <= 1'b0;
			mode_chain <= 1'b0;
			bit_cnt    <= 8'h00;
			in_shift   <= 24'h000000;
		end else if (cs_fall) begin
			in_frame   <= 1'b1;
			mode_crc   <= ~nocrc_s;
			mode_chain <= chain_s;
			bit_cnt    <= 8'h00;
		end else if (cs_rise) begin
			in_frame <= 1'b0;
		end else if (sclk_rise) begin
			bit_cnt  <= bit_cnt + 8'h01; // [R21]
			in_shift <= {in_shift[22:0], sdi_s}; // [R20]
		end
	end

	// outgoing word; byte two filled early in direct reads
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_word     <= 24'h000000;
			load_pending <= 1'b0;
		end else if (cs_fall) begin
			out_word     <= {hold, chain_byte, slow, smiss, 6'h00}; // [R16]
			load_pending <= 1'b0;
		end else if (sclk_rise && bit_cnt == 8'h07 && !mode_chain) begin
			load_pending <= ~in_shift[6]; // [R10]
		end else if (load_pending) begin
			out_word[15:8] <= read_value; // [R8] [R17]
			load_pending   <= 1'b0;
		end
	end

	// serial output, advanced on falling sclk
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sdo     <= 1'b0;
			sdo_oe  <= 1'b0;
			out_idx <= 6'h00;
		end else if (cs_fall) begin
			sdo     <= hold[7];
			sdo_oe  <= 1'b1;
			out_idx <= 6'h00;
		end else if (cs_rise) begin
			sdo_oe <= 1'b0;
			sdo    <= 1'b0;
		end else if (sclk_fall) begin
			out_idx <= next_idx;
			sdo     <= next_bit; // [R20] [R11] [R12]
		end
	end

	// read address: mid-frame in direct modes, at frame end for chains
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_addr   <= 7'h00;
			prev_read <= 1'b0;
		end else if (sclk_rise && bit_cnt == 8'h07 && !mode_chain) begin
			rd_addr <= {in_shift[5:0], sdi_s};
		end else if (valid) begin
			prev_read <= ~cmd_write; // [R14]
			if (!cmd_write) begin
				rd_addr <= cmd_addr; // [R11] [R12]
			end
		end else if (cs_rise) begin
			prev_read <= 1'b0;
		end
	end

	// fault flags; a still-present condition beats the clear on read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			crc_err <= 1'b0;
			por     <= 1'b1; // [R2]
			slow    <= 1'b0;
			smiss   <= 1'b0;
			clk8    <= 1'b0;
			otemp   <= 1'b0;
		end else begin
			crc_err <= crc_bad | (crc_err & ~(valid & mode_crc)); // [R22]
			por   <= por & ~(wr_f1 & ~cmd_data[spi_port_pkg::F1_POR]); // [R2]
			slow  <= slow_s | (slow & ~rd_f1); // [R7]
			smiss <= smiss_s | (smiss & ~rd_f1); // [R7]
			clk8  <= bad_count | (clk8 & ~rd_f2); // [R21] [R7]
			otemp <= otemp_s | (otemp & ~rd_f2); // [R7]
		end
	end

	// alarm enables and sticky select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			f1_en <= spi_port_pkg::MAIN_FAULT_STATUS_REGISTER_EN_RESET; // [R3]
			f2_en <= spi_port_pkg::SECONDARY_FAULT_STATUS_EN_RESET;
			gpo   <= spi_port_pkg::GPO_RESET;
		end else begin
			if (wr_f1e) begin
				f1_en <= cmd_data; // [R5]
			end
			if (wr_f2e) begin
				f2_en <= cmd_data;
			end
			if (wr_gpo) begin
				gpo <= cmd_data;
			end
		end
	end

	// open-drain alarm: sticky holds until main status is read
	wire alarm_src = |(main_fault_status_register & f1_en);
	wire alarm_now = gpo[spi_port_pkg::GPO_STICKY] ? alarm_latched
		: alarm_src; // [R5]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			alarm_latched <= 1'b0;
			alarm_n_oe    <= 1'b0;
			alarm_n_out   <= 1'b0;
		end else begin
			alarm_latched <= alarm_src | (alarm_latched & ~rd_f1);
			alarm_n_oe    <= alarm_now; // [R4]
			alarm_n_out   <= 1'b0;
		end
	end

	// writes for the outside register file wait here for the buffer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			exec_valid <= 1'b0;
			exec_cmd   <= '0;
		end else if (wr_ext) begin
			exec_valid <= 1'b1;
			exec_cmd   <= '{write: 1'b1, addr: cmd_addr, data: cmd_data};
		end else if (buf_ready) begin
			exec_valid <= 1'b0;
		end
	end

	two_entry_buffer #(
		.WIDTH ($bits(spi_port_pkg::cmd_t)),
		.DEPTH (BUF_DEPTH)
	) u_wr_buffer (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (exec_valid),
		.in_ready  (buf_ready),
		.in_data   (exec_cmd),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_cmd)
	);
endmodule
`default_nettype wire

// [testbench/spi_port_assertions.sv]
`default_nettype none
module spi_port_assertions (
	input wire logic               clock,       // system clock
	input wire logic               rst,         // async reset, high
	input wire logic               sclk,        // serial clock pin
	input wire logic               cs_n,        // chip select pin
	input wire logic               sdo,         // serial data out
	input wire logic               sdo_oe,      // sdo driven
	input wire logic               ready_n,     // low = powered up
	input wire logic               alarm_n_out, // alarm level
	input wire logic               alarm_n_oe,  // alarm pulled low
	input wire logic               wr_valid,    // outside write valid
	input wire spi_port_pkg::cmd_t wr_cmd,      // outside write word
	input wire logic               wr_ready     // outside takes word
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// cycles since reset release, saturating
	logic [7:0] up_cnt;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			up_cnt <= 8'h00;
		end else if (up_cnt != 8'hff) begin
			up_cnt <= up_cnt + 8'h01;
		end
	end

	// chip select idle long enough for the frame to close
	sequence s_cs_idle;
		cs_n [*6];
	endsequence
	// a word offered and not yet taken
	sequence s_wait_take;
		wr_valid && !wr_ready;
	endsequence

	chk_ready_not_early: assert property (up_cnt < 8'h62 |-> ready_n)
		else $error("ready before power-up count");
	chk_ready_stays_low: assert property (!ready_n |=> !ready_n)
		else $error("ready went back high");
	chk_no_frame_early: assert property (ready_n |-> !sdo_oe)
		else $error("frame opened before ready");
	chk_por_alarm_on: assert property (up_cnt == 8'h04 |-> alarm_n_oe)
		else $error("alarm not asserted after power-up");
	chk_alarm_drives_low: assert property (alarm_n_oe |-> !alarm_n_out)
		else $error("alarm pin driven high");
	chk_sdo_idle_off: assert property (s_cs_idle |-> !sdo_oe)
		else $error("sdo driven outside a frame");
	chk_sdo_on_fall: assert property ($changed(sdo) && sdo_oe &&
		$past(sdo_oe) |-> !$past(sclk, 2))
		else $error("sdo changed away from a falling clock");
	chk_write_holds: assert property (s_wait_take |=>
		wr_valid && $stable(wr_cmd))
		else $error("offered write dropped or changed");
	chk_write_after_frame: assert property ($rose(wr_valid) |-> cs_n)
		else $error("write issued inside a frame");
endmodule
bind octal_input_spi_frame_port spi_port_assertions chk (
	.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
	.sdo_oe(sdo_oe), .ready_n(ready_n), .alarm_n_out(alarm_n_out),
	.alarm_n_oe(alarm_n_oe), .wr_valid(wr_valid), .wr_cmd(wr_cmd),
	.wr_ready(wr_ready)
);
`default_nettype wire

// [testbench/spi_host.sv]
`default_nettype none
module spi_host (
	input  wire logic clock, // system clock
	input  wire logic miso,  // resolved device output
	output logic      sclk,  // serial clock, idles low
	output logic      cs_n,  // chip select
	output logic      mosi   // serial data to device
);
	timeunit 1ns;
	timeprecision 100ps;

	// lines idle before the first frame
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// host check word over 19 bits before the seed 00111
	function automatic logic [4:0] crc(input logic [18:0] d);
		logic [23:0] w;
		logic [4:0]  r;
		w = {d, 5'h07};
		r = 5'h00;
		for (int i = 23; i >= 0; i--) begin
			r = r[4] ? ({r[3:0], w[i]} ^ 5'h15) : {r[3:0], w[i]};
		end
		return r;
	endfunction

	// one frame msb first: data set on falls, sampled on rises
	task automatic xfer(input logic [23:0] tx, input int n,
		output logic [23:0] rx);
		rx = 24'h000000;
		@(posedge clock);
		cs_n <= 1'b0;
		mosi <= tx[n-1];
		for (int i = n - 1; i >= 0; i--) begin
			#62.5 sclk <= 1'b1;
			rx = {rx[22:0], miso};
			#62.5 sclk <= 1'b0;
			if (i > 0) begin
				mosi <= tx[i-1];
			end
		end
		#62.5;
		@(posedge clock);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic               clock, rst, sclk, cs_n, mosi, sdo, sdo_oe;
	logic               miso, sample_freeze_n, crc_select_pin;
	logic               chain_select_pin, supply_low_in, supply_miss_in;
	logic               overtemp_in, ready_n, alarm_n_out, alarm_n_oe;
	logic               alarm_pin, wr_valid, wr_ready;
	logic [7:0]         channel_in, rd_data, chan_exp;
	logic [6:0]         rd_addr;
	spi_port_pkg::cmd_t wr_cmd;
	spi_port_pkg::cmd_t got[$];
	int                 miscompares, n_compared, cycles;

	// released lines: sdo inverted when not driven, alarm pulled up
	assign miso      = sdo_oe ? sdo : ~sdo;
	assign alarm_pin = alarm_n_oe ? alarm_n_out : 1'b1;
	assign rd_data   = {1'b1, rd_addr};

	octal_input_spi_frame_port dut (.clock(clock), .rst(rst),
		.sclk(sclk), .cs_n(cs_n), .sdi(mosi), .sdo(sdo), .sdo_oe(sdo_oe),
		.sample_freeze_n(sample_freeze_n), .crc_select_pin(crc_select_pin),
		.chain_select_pin(chain_select_pin), .channel_in(channel_in),
		.supply_low_in(supply_low_in), .supply_miss_in(supply_miss_in),
		.overtemp_in(overtemp_in), .ready_n(ready_n),
		.alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe),
		.wr_valid(wr_valid), .wr_cmd(wr_cmd), .wr_ready(wr_ready),
		.rd_addr(rd_addr), .rd_data(rd_data));
	spi_host host (.clock(clock), .miso(miso), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi));

	// clock and hang limit
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (wr_valid && wr_ready) begin
			got.push_back(wr_cmd);
		end
		if (cycles == 30000) begin
			miscompares++;
			results();
		end
	end

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] seen);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic run(input logic m1, input logic m0, input logic [23:0] tx,
		input int n, output logic [23:0] rx);
		@(posedge clock);
		chain_select_pin <= m1;
		crc_select_pin   <= m0;
		host.xfer(tx, n, rx);
	endtask

	function automatic logic [23:0] cf(input logic [18:0] d);
		return {d, host.crc(d)};
	endfunction

	// one full frame, whole returned frame compared
	task automatic op(input logic m1, input logic m0, input logic rw,
		input logic [6:0] a, input logic [7:0] d, input logic [7:0] b2,
		input logic [1:0] fl, input logic bad);
		logic [23:0] rx;
		if (!m0) begin
			run(m1, m0, cf({rw, a, d, 3'h5}) ^ {23'h0, bad}, 24, rx);
			chk("crc frame", cf({chan_exp, b2, fl, 1'b0}), rx);
		end else begin
			run(m1, m0, {8'h00, rw, a, d}, 16, rx);
			chk("plain frame", {8'h00, chan_exp, b2}, rx);
		end
	endtask

	task automatic t_power();
		for (int i = 0; i < 300 && ready_n !== 1'b0; i++) @(posedge clock);
		chk("ready", 24'h0, {23'h0, ready_n});
		chk("alarm", 24'h0, {23'h0, alarm_pin});
		op(1'b0, 1'b1, 1'b0, 7'h04, 8'h00, 8'h40, 2'b00, 1'b0);
		op(1'b0, 1'b1, 1'b0, 7'h24, 8'h00, 8'hc0, 2'b00, 1'b0);
		op(1'b0, 1'b1, 1'b1, 7'h04, 8'h00, 8'h00, 2'b00, 1'b0);
		repeat (6) @(posedge clock);
		chk("alarm", 24'h1, {23'h0, alarm_pin});
		$display("power-up test done");
	endtask

	task automatic t_crc();
		op(1'b0, 1'b0, 1'b1, 7'h06, 8'h5a, 8'h00, 2'b00, 1'b0);
		op(1'b0, 1'b0, 1'b1, 7'h08, 8'h3c, 8'h00, 2'b00, 1'b0);
		chk("write head", 24'h01865a, {7'h0, wr_valid, wr_cmd});
		wr_ready <= 1'b1;
		repeat (4) @(posedge clock);
		wr_ready <= 1'b0;
		chk("word one", 24'h00865a, {8'h00, got[0]});
		chk("word two", 24'h00883c, {8'h00, got[1]});
		op(1'b0, 1'b0, 1'b0, 7'h06, 8'h00, 8'h86, 2'b00, 1'b0);
		op(1'b0, 1'b0, 1'b0, 7'h24, 8'h00, 8'hc0, 2'b00, 1'b0);
		op(1'b0, 1'b0, 1'b1, 7'h06, 8'h11, 8'h00, 2'b00, 1'b1);
		repeat (4) @(posedge clock);
		chk("alarm", 24'h0, {23'h0, alarm_pin});
		op(1'b0, 1'b0, 1'b0, 7'h04, 8'h00, 8'h80, 2'b00, 1'b0);
		repeat (6) @(posedge clock);
		chk("alarm", 24'h1, {23'h0, alarm_pin});
		$display("crc test done");
	endtask

	// sticky alarm outlives its source until main status is read
	task automatic t_sticky();
		op(1'b0, 1'b1, 1'b1, 7'h22, 8'h80, 8'h00, 2'b00, 1'b0);
		op(1'b0, 1'b1, 1'b0, 7'h04, 8'h00, 8'h00, 2'b00, 1'b0);
		chk("alarm", 24'h1, {23'h0, alarm_pin});
		op(1'b0, 1'b0, 1'b1, 7'h06, 8'h11, 8'h00, 2'b00, 1'b1);
		op(1'b0, 1'b0, 1'b0, 7'h24, 8'h00, 8'hc0, 2'b00, 1'b0);
		chk("alarm", 24'h0, {23'h0, alarm_pin});
		op(1'b0, 1'b1, 1'b0, 7'h04, 8'h00, 8'h00, 2'b00, 1'b0);
		chk("alarm", 24'h1, {23'h0, alarm_pin});
		$display("sticky test done");
	endtask

	task automatic t_count();
		logic [23:0] rx;
		run(1'b0, 1'b1, 24'h000860, 12, rx);
		op(1'b0, 1'b1, 1'b0, 7'h1c, 8'h00, 8'h10, 2'b00, 1'b0);
		op(1'b0, 1'b1, 1'b0, 7'h1c, 8'h00, 8'h00, 2'b00, 1'b0);
		run(1'b0, 1'b1, 24'h000086, 8, rx);
		chk("input byte", {16'h0, chan_exp}, rx);
		repeat (4) @(posedge clock);
		chk("word count", 24'd2, 24'(got.size()));
		$display("clock count test done");
	endtask

	task automatic t_freeze();
		sample_freeze_n <= 1'b0;
		@(posedge clock);
		channel_in    <= 8'h3c;
		supply_low_in <= 1'b1;
		repeat (4) @(posedge clock);
		op(1'b0, 1'b0, 1'b0, 7'h02, 8'h00, 8'ha5, 2'b10, 1'b0);
		chk("alarm", 24'h1, {23'h0, alarm_pin});
		sample_freeze_n <= 1'b1;
		supply_low_in   <= 1'b0;
		chan_exp = 8'h3c;
		repeat (4) @(posedge clock);
		op(1'b0, 1'b1, 1'b0, 7'h04, 8'h00, 8'h04, 2'b00, 1'b0);
		op(1'b0, 1'b1, 1'b0, 7'h04, 8'h00, 8'h00, 2'b00, 1'b0);
		$display("freeze test done");
	endtask

	// chain: second byte follows the preceding frame
	task automatic t_chain();
		logic [23:0] rx;
		for (int k = 0; k < 2; k++) begin
			run(1'b1, 1'(k), k ? 24'h009c00 : cf({1'b1, 7'h1c, 8'h00,
				3'h5}), k ? 16 : 24, rx);
			op(1'b1, 1'(k), 1'b0, 7'h24, 8'h00, 8'h00, 2'b00, 1'b0);
			op(1'b1, 1'(k), 1'b1, 7'h1c, 8'h00, 8'hc0, 2'b00, 1'b0);
			op(1'b1, 1'(k), 1'b0, 7'h24, 8'h00, 8'h00, 2'b00, 1'b0);
		end
		$display("chain test done");
	endtask

	initial begin
		rst              = 1'b1;
		sample_freeze_n  = 1'b1;
		crc_select_pin   = 1'b1;
		chain_select_pin = 1'b0;
		channel_in       = 8'ha5;
		chan_exp         = 8'ha5;
		supply_low_in    = 1'b0;
		supply_miss_in   = 1'b0;
		overtemp_in      = 1'b0;
		wr_ready         = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_power();
		t_crc();
		t_sticky();
		t_count();
		t_freeze();
		t_chain();
		results();
	end
endmodule
`default_nettype wire
